// ---- test/dio_field_model.sv ----
// dio_field_model: field side of the block, contacts and linked module levels
// assumes: the bench commands levels; they reach the block one clock later
`timescale 1ns/1ps
module dio_field_model
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // levels commanded by the bench
   input  wire logic [2:0]        contact_i,
   input  wire dio_pkg::dio_src_t src_i,
   // levels seen by the block
   output logic [2:0]             contact_o,
   output dio_pkg::dio_src_t      src_o
);
   // contacts arrive debounced and clock aligned, as the block expects
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         contact_o <= 3'h0;
         src_o     <= '0;
      end
      else
      begin
         contact_o <= contact_i;
         src_o     <= src_i;
      end
   end
endmodule

// ---- test/tb_top.sv ----
// tb_top: self-checking bench for dio_top over classic wishbone
// assumes: dio_field_model stands for the contacts and linked modules
`timescale 1ns/1ps
module tb_top;
   // bus side
   logic              mclk, rst, cyc, stb, we, ack, err, irq, bus_err;
   logic [7:0]        adr, dout, e;
   logic [3:0]        sel;
   logic [31:0]       wdat, rdat, dat_o, av;
   dio_pkg::dio_state_t st;
   // field side: commands and what the block sees
   logic [2:0]        cmd_ct, ct;
   dio_pkg::dio_src_t cmd_src, src;
   dio_pkg::dio_src_t pat [3];
   int                err_count, tests_run, i, k, c, o;
   localparam logic [7:0] man_pat = 8'h5a; // manual bits written by the bench

   dio_field_model field (.clk_i(mclk), .rst_i(rst), .contact_i(cmd_ct), .src_i(cmd_src),
                          .contact_o(ct), .src_o(src));
   dio_top dut (.MCLK_I(mclk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
                .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack),
                .ERR_O(err), .AUTO_MANUAL_SELECT_I(ct[0]), .REMOTE_LOCAL_SELECT_I(ct[1]),
                .RUN_CONTACT_I(ct[2]), .SRC_I(src), .DOUT_O(dout), .STATE_O(st), .IRQ_O(irq));

   // 200 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // verdict and end of run, also reached by a timed-out wait
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one classic cycle; request held until ack or err is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      @(posedge mclk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (ack !== 1'b1 && err !== 1'b1 && n < 64);
      // a silent slave ends the run rather than hanging it
      if (n >= 64)
      begin
         err_count++;
         complete_run();
      end
      rdat    = dat_o;
      bus_err = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // expected level of output o for assignment value v
   function automatic logic exp_bit(input logic [3:0] v, input int o,
                                    input dio_pkg::dio_src_t s, input logic [1:0] h);
      int p;
      p = o % 4;
      case (v)
         4'h1: return man_pat[o];
         4'h2: return s.chan_event[0][p] | s.chan_event[1][p] | s.chan_event[2][p]
                      | s.chan_event[3][p];
         4'h3, 4'h4, 4'h5, 4'h6: return s.chan_event[v - 4'h3][p];
         4'h7, 4'h8, 4'h9, 4'ha: return s.chan_event[p][v - 4'h7];
         4'hb: return s.heater_break_alarm[p];
         4'hc: return s.burnout[p];
         4'hd:
            case (p)
               0: return &(s.rise_done | ~s.rise_sel);
               1: return (h != 2'h1 && |s.heater_break_alarm)
                         || (h != 2'h0 && |s.ct_break);
               2: return |s.burnout;
               default: return man_pat[o];
            endcase
         default: return 1'b0;
      endcase
   endfunction

   initial
   begin
      rst = 1'b1;
      {cyc, stb, we, adr, sel, wdat, cmd_ct} = '0;
      cmd_src = '0;
      err_count = 0;
      tests_run = 0;
      // diagonal events, rise done, temperature module alarm only
      pat[0] = {16'h8421, 4'h1, 12'h000, 4'h0, 4'h3, 4'h3};
      // one rise pending, current transformer alarm only
      pat[1] = {16'h00f2, 4'h0, 12'h800, 4'h4, 4'h5, 4'h1};
      // no rise selected, temperature module alarm on channel 4
      pat[2] = {16'h3000, 4'h8, 12'h000, 4'h0, 4'h0, 4'h0};
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      // reset values
      wb(1'b0, dio_pkg::DIO_OFF_CTRL, 32'h0, 4'hf);
      chk(rdat, dio_pkg::DIO_CTRL_RST);
      wb(1'b0, dio_pkg::DIO_OFF_ASGN_A, 32'h0, 4'hf);
      chk(rdat, 32'h0);
      chk({24'h0, dout}, 32'h0);
      // contact against comm, linked and not
      for (i = 0; i < 8; i++)
      begin
         cmd_ct <= {3{i[0]}};
         wb(1'b1, dio_pkg::DIO_OFF_CTRL, {27'h0, {3{i[1]}}, {2{i[2]}}}, 4'hf);
         ticks(3);
         e = {5'h0, i[0] & i[1], {2{i[2] ? i[0] : i[1]}}};
         chk({29'h0, st}, {24'h0, e});
         wb(1'b0, dio_pkg::DIO_OFF_STATE, 32'h0, 4'hf);
         chk({29'h0, rdat[2:0]}, {24'h0, e});
      end
      // read-only state ignores writes; unmapped place is refused
      wb(1'b1, dio_pkg::DIO_OFF_STATE, 32'h0, 4'hf);
      wb(1'b0, dio_pkg::DIO_OFF_STATE, 32'h0, 4'hf);
      chk({29'h0, rdat[2:0]}, 32'h7);
      wb(1'b0, 8'h20, 32'h0, 4'hf);
      chk({31'h0, bus_err}, 32'h1);
      // interrupt: raise, mask, clear
      cmd_ct <= 3'h0;
      wb(1'b1, dio_pkg::DIO_OFF_CTRL, 32'h3, 4'hf);
      ticks(3);
      wb(1'b1, dio_pkg::DIO_OFF_IMASK, 32'h0, 4'hf);
      wb(1'b1, dio_pkg::DIO_OFF_ISTAT, 32'hf, 4'hf);
      cmd_ct <= 3'h1;
      ticks(4);
      wb(1'b0, dio_pkg::DIO_OFF_ISTAT, 32'h0, 4'hf);
      chk(rdat, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, dio_pkg::DIO_OFF_IMASK, 32'h1, 4'hf);
      ticks(1);
      chk({31'h0, irq}, 32'h1);
      wb(1'b1, dio_pkg::DIO_OFF_ISTAT, 32'h1, 4'hf);
      ticks(1);
      chk({31'h0, irq}, 32'h0);
      // remote and run changes set their own events; masked, so no interrupt
      cmd_ct <= 3'h7;
      wb(1'b1, dio_pkg::DIO_OFF_CTRL, 32'h13, 4'hf);
      ticks(3);
      wb(1'b0, dio_pkg::DIO_OFF_ISTAT, 32'h0, 4'hf);
      chk(rdat, 32'h6);
      chk({31'h0, irq}, 32'h0);
      // every assignment value on every output position
      wb(1'b1, dio_pkg::DIO_OFF_MANUAL, {24'h0, man_pat}, 4'hf);
      for (k = 0; k < 3; k++)
      begin
         cmd_src <= pat[k];
         wb(1'b1, dio_pkg::DIO_OFF_CTRL, {25'h0, 2'(k), 5'h0}, 4'hf);
         for (c = 0; c < 16; c++)
         begin
            for (o = 0; o < 8; o++)
               av[o*4 +: 4] = 4'(c + o);
            wb(1'b1, dio_pkg::DIO_OFF_ASGN_A, {16'h0, av[15:0]}, 4'hf);
            wb(1'b1, dio_pkg::DIO_OFF_ASGN_B, {16'h0, av[31:16]}, 4'hf);
            ticks(2);
            for (o = 0; o < 8; o++)
               e[o] = exp_bit(av[o*4 +: 4], o, pat[k], 2'(k));
            chk({24'h0, dout}, {24'h0, e});
            wb(1'b0, dio_pkg::DIO_OFF_DOUT, 32'h0, 4'hf);
            chk(rdat, {24'h0, e});
         end
      end
      // byte lane 0 alone reaches outputs 1 and 2
      wb(1'b1, dio_pkg::DIO_OFF_ASGN_A, 32'h0, 4'hf);
      wb(1'b1, dio_pkg::DIO_OFF_ASGN_A, 32'hffff_ffff, 4'h1);
      wb(1'b0, dio_pkg::DIO_OFF_ASGN_A, 32'h0, 4'hf);
      chk(rdat, 32'h0000_00ff);
      // an output change leaves its sticky event behind
      wb(1'b1, dio_pkg::DIO_OFF_ISTAT, 32'hf, 4'hf);
      wb(1'b1, dio_pkg::DIO_OFF_ASGN_A, 32'h10, 4'hf);
      ticks(2);
      chk({28'h0, dout[3:0]}, 32'h2);
      wb(1'b0, dio_pkg::DIO_OFF_ISTAT, 32'h0, 4'hf);
      chk(rdat, 32'h8);
      complete_run();
   end
endmodule

// ---- verilog/dio_outsel.sv ----
// dio_outsel: combinational source selection for eight contact outputs
// assumes: sources are synchronous and stable at the clock
`timescale 1ns/1ps
module dio_outsel
(
   // configuration
   input  wire logic [7:0][3:0] asgn_i,
   input  wire logic [7:0]      manual_i,
   input  wire logic [1:0]      brk_sel_i,
   // sources
   input  wire dio_pkg::dio_src_t src_i,
   // selected levels
   output logic [7:0]           dout_o
);
   logic [3:0] ev_or;   // per event, or across channels
   logic       brk_or;  // chosen heater break summary
   logic       rise_ok; // all selected channels done
   logic       burn_or; // any burnout

   // summary terms shared by both groups of four
   always_comb
   begin
      for (int e = 0; e < 4; e++)
      begin
         ev_or[e] = src_i.chan_event[0][e] | src_i.chan_event[1][e]
                  | src_i.chan_event[2][e] | src_i.chan_event[3][e];
      end
      burn_or = |src_i.burnout;
      // channels not set to rise completion do not hold it back
      rise_ok = &(src_i.rise_done | ~src_i.rise_sel);
      if (brk_sel_i == dio_pkg::DIO_BRK_CT)
         brk_or = |src_i.ct_break;
      else if (brk_sel_i == dio_pkg::DIO_BRK_BOTH)
         brk_or = (|src_i.ct_break) | (|src_i.heater_break_alarm);
      else
         brk_or = |src_i.heater_break_alarm;
   end

   // per output mux; position p is the index within its group
   always_comb
   begin
      int p;
      p = 0;
      for (int o = 0; o < 8; o++)
      begin
         p = o % 4;
         unique case (asgn_i[o])
            dio_pkg::DIO_A_NONE:   dout_o[o] = 1'b0;
            dio_pkg::DIO_A_MANUAL: dout_o[o] = manual_i[o];
            dio_pkg::DIO_A_EVOR:   dout_o[o] = ev_or[p];
            dio_pkg::DIO_A_BREAK:  dout_o[o] = src_i.heater_break_alarm[p];
            dio_pkg::DIO_A_BURN:   dout_o[o] = src_i.burnout[p];
            dio_pkg::DIO_A_COMBO:
            begin
               case (p)
                  0:       dout_o[o] = rise_ok;
                  1:       dout_o[o] = brk_or;
                  2:       dout_o[o] = burn_or;
                  default: dout_o[o] = manual_i[o];
               endcase
            end
            default:
            begin
               // 3..6 one channel's events, 7..10 one event over channels
               if (asgn_i[o] >= dio_pkg::DIO_A_CH1 && asgn_i[o] <= dio_pkg::DIO_A_CH4)
                  dout_o[o] = src_i.chan_event[2'(asgn_i[o] - dio_pkg::DIO_A_CH1)][p];
               else if (asgn_i[o] >= dio_pkg::DIO_A_EV1 && asgn_i[o] <= dio_pkg::DIO_A_EV4)
                  dout_o[o] = src_i.chan_event[p][2'(asgn_i[o] - dio_pkg::DIO_A_EV1)];
               else
                  dout_o[o] = 1'b0; // 14, 15 unused
            end
         endcase
      end
   end
endmodule

// ---- verilog/dio_pkg.sv ----
// dio_pkg: constants, register map and carrier types of the digital i/o state and output block
// assumes: a classic wishbone slave with 32-bit data and byte addresses
package dio_pkg;
   // register byte offsets
   localparam logic [7:0] DIO_OFF_CTRL   = 8'h00; // comm commands and select bits
   localparam logic [7:0] DIO_OFF_STATE  = 8'h04; // actual device states, read only
   localparam logic [7:0] DIO_OFF_ASGN_A = 8'h08; // assignment values of outputs 1..4
   localparam logic [7:0] DIO_OFF_ASGN_B = 8'h0c; // assignment values of outputs 5..8
   localparam logic [7:0] DIO_OFF_MANUAL = 8'h10; // manual output bits
   localparam logic [7:0] DIO_OFF_DOUT   = 8'h14; // contact output levels, read only
   localparam logic [7:0] DIO_OFF_ISTAT  = 8'h18; // sticky events, write one to clear
   localparam logic [7:0] DIO_OFF_IMASK  = 8'h1c; // interrupt enables
   // control register fields
   localparam int DIO_CTRL_AM_LINK  = 0; // auto/manual assigned to contact, linked
   localparam int DIO_CTRL_RL_LINK  = 1; // remote/local assigned to contact, linked
   localparam int DIO_CTRL_COMM_MAN = 2; // comm commanded manual
   localparam int DIO_CTRL_COMM_REM = 3; // comm commanded remote
   localparam int DIO_CTRL_COMM_RUN = 4; // comm commanded run
   localparam int DIO_CTRL_BRK_LSB  = 5; // 2-bit heater break source choice
   // state register / status fields
   localparam int DIO_ST_MAN = 0;
   localparam int DIO_ST_REM = 1;
   localparam int DIO_ST_RUN = 2;
   localparam int DIO_ST_DO  = 3; // any output changed
   // reset values
   localparam logic [31:0] DIO_CTRL_RST = 32'h0000_0000;
   localparam logic [3:0]  DIO_ASGN_RST = 4'h0;
   // heater break source choice
   localparam logic [1:0] DIO_BRK_TEMP = 2'h0;
   localparam logic [1:0] DIO_BRK_CT   = 2'h1;
   localparam logic [1:0] DIO_BRK_BOTH = 2'h2;
   // assignment value codes
   localparam logic [3:0] DIO_A_NONE   = 4'h0;
   localparam logic [3:0] DIO_A_MANUAL = 4'h1;
   localparam logic [3:0] DIO_A_EVOR   = 4'h2;
   localparam logic [3:0] DIO_A_CH1    = 4'h3;
   localparam logic [3:0] DIO_A_CH4    = 4'h6;
   localparam logic [3:0] DIO_A_EV1    = 4'h7;
   localparam logic [3:0] DIO_A_EV4    = 4'ha;
   localparam logic [3:0] DIO_A_BREAK  = 4'hb;
   localparam logic [3:0] DIO_A_BURN   = 4'hc;
   localparam logic [3:0] DIO_A_COMBO  = 4'hd;
   // field inputs coming from the linked modules
   typedef struct packed {
      logic [3:0][3:0] chan_event; // [channel][event]
      logic [3:0]      heater_break_alarm;
      logic [11:0]     ct_break;   // current transformer module alarms
      logic [3:0]      burnout;
      logic [3:0]      rise_sel;   // event 3 set as rise completion
      logic [3:0]      rise_done;
   } dio_src_t;
   // actual device states
   typedef struct packed {
      logic run;
      logic remote;
      logic manual;
   } dio_state_t;
endpackage

// ---- verilog/dio_top.sv ----
// dio_top: actual state resolution and contact output drive with a wishbone register file
// assumes: contact inputs already debounced and synchronous to MCLK_I
// Summary of operation
// - linked auto/manual follows contact, closed means manual
// - linked remote/local follows contact, closed means remote
// - run needs closed contact and comm run
// - per output value 0..13; 0 off, 1 manual
// - value 2: or of event n over channels
// - value 11: heater break alarm channel n
// - value 13 third: or of burnout states
// - value 13 first: all rise completions done
// - value 13 second: chosen heater break or
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module dio_top
(
   // clock and reset
   input  wire logic              MCLK_I,
   input  wire logic              RST_I,
   // wishbone slave
   input  wire logic              CYC_I,
   input  wire logic              STB_I,
   input  wire logic              WE_I,
   input  wire logic [7:0]        ADR_I,
   input  wire logic [3:0]        SEL_I,
   input  wire logic [31:0]       DAT_I,
   output logic [31:0]            DAT_O,
   output logic                   ACK_O,
   output logic                   ERR_O,
   // field contacts
   input  wire logic              AUTO_MANUAL_SELECT_I,
   input  wire logic              REMOTE_LOCAL_SELECT_I,
   input  wire logic              RUN_CONTACT_I,
   input  wire dio_pkg::dio_src_t SRC_I,
   // outputs
   output logic [7:0]             DOUT_O,
   output dio_pkg::dio_state_t    STATE_O,
   output logic                   IRQ_O
);
   logic [31:0]      ctrl_r, ctrl_nxt;       // commands and select bits
   logic [7:0][3:0]  asgn_r, asgn_nxt;       // assignment values
   logic [7:0]       man_r, man_nxt;         // manual bits
   logic [3:0]       ist_r, ist_nxt;         // sticky events
   logic [3:0]       imask_r, imask_nxt;     // enables
   logic [7:0]       dout_r, dout_nxt;       // registered outputs
   dio_pkg::dio_state_t st_r, st_nxt;        // actual states
   logic             ack_r, ack_nxt;
   logic             err_r, err_nxt;
   logic [31:0]      rdat_r, rdat_nxt;
   logic [7:0]       sel_dout;               // mux result
   logic             req;                    // new bus request
   logic [2:0]       st_evt;                 // state change events
   logic [3:0]       evt;

   // byte-lane merge used by every writable register except the sticky events, which clear from lane 0
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (sel[b])
            r[b*8 +: 8] = d[b*8 +: 8];
      return r;
   endfunction

   dio_outsel u_sel
   (
      .asgn_i    (asgn_r),
      .manual_i  (man_r),
      .brk_sel_i (ctrl_r[dio_pkg::DIO_CTRL_BRK_LSB +: 2]),
      .src_i     (SRC_I),
      .dout_o    (sel_dout)
   );

   // request taken once; ack drops in the cycle after it was given
   assign req = CYC_I && STB_I && !ack_r && !err_r;

   // actual state resolution
   always_comb
   begin
      // when not linked, communication alone decides
      if (ctrl_r[dio_pkg::DIO_CTRL_AM_LINK])
         st_nxt.manual = AUTO_MANUAL_SELECT_I;
      else
         st_nxt.manual = ctrl_r[dio_pkg::DIO_CTRL_COMM_MAN];
      if (ctrl_r[dio_pkg::DIO_CTRL_RL_LINK])
         st_nxt.remote = REMOTE_LOCAL_SELECT_I;
      else
         st_nxt.remote = ctrl_r[dio_pkg::DIO_CTRL_COMM_REM];
      // stop wins from either side
      st_nxt.run = RUN_CONTACT_I && ctrl_r[dio_pkg::DIO_CTRL_COMM_RUN];
      dout_nxt   = sel_dout;
   end

   assign st_evt = st_nxt ^ st_r;
   assign evt    = {|(dout_nxt ^ dout_r), st_evt[2], st_evt[1], st_evt[0]};

   // register file and bus answer
   always_comb
   begin
      ctrl_nxt  = ctrl_r;
      asgn_nxt  = asgn_r;
      man_nxt   = man_r;
      imask_nxt = imask_r;
      ist_nxt   = ist_r;
      ack_nxt   = 1'b0;
      err_nxt   = 1'b0;
      rdat_nxt  = rdat_r;
      if (req && WE_I)
      begin
         if (ADR_I == dio_pkg::DIO_OFF_CTRL)
         begin
            ctrl_nxt = merge(ctrl_r, DAT_I, SEL_I) & 32'h0000_007f;
            ack_nxt  = 1'b1;
         end
         else if (ADR_I == dio_pkg::DIO_OFF_ASGN_A)
         begin
            asgn_nxt[3:0] = 16'(merge({16'h0, asgn_r[3:0]}, DAT_I, SEL_I));
            ack_nxt  = 1'b1;
         end
         else if (ADR_I == dio_pkg::DIO_OFF_ASGN_B)
         begin
            asgn_nxt[7:4] = 16'(merge({16'h0, asgn_r[7:4]}, DAT_I, SEL_I));
            ack_nxt  = 1'b1;
         end
         else if (ADR_I == dio_pkg::DIO_OFF_MANUAL)
         begin
            man_nxt = 8'(merge({24'h0, man_r}, DAT_I, SEL_I));
            ack_nxt = 1'b1;
         end
         else if (ADR_I == dio_pkg::DIO_OFF_ISTAT)
         begin
            if (SEL_I[0])
               ist_nxt = ist_r & ~DAT_I[3:0];
            ack_nxt = 1'b1;
         end
         else if (ADR_I == dio_pkg::DIO_OFF_IMASK)
         begin
            imask_nxt = 4'(merge({28'h0, imask_r}, DAT_I, SEL_I));
            ack_nxt   = 1'b1;
         end
         else if (ADR_I == dio_pkg::DIO_OFF_STATE || ADR_I == dio_pkg::DIO_OFF_DOUT)
            ack_nxt = 1'b1; // read-only, write ignored
         else
            err_nxt = 1'b1;
      end
      else if (req)
      begin
         ack_nxt = 1'b1;
         if (ADR_I == dio_pkg::DIO_OFF_CTRL)
            rdat_nxt = ctrl_r;
         else if (ADR_I == dio_pkg::DIO_OFF_STATE)
            rdat_nxt = {29'h0, st_r};
         else if (ADR_I == dio_pkg::DIO_OFF_ASGN_A)
            rdat_nxt = {16'h0, asgn_r[3:0]};
         else if (ADR_I == dio_pkg::DIO_OFF_ASGN_B)
            rdat_nxt = {16'h0, asgn_r[7:4]};
         else if (ADR_I == dio_pkg::DIO_OFF_MANUAL)
            rdat_nxt = {24'h0, man_r};
         else if (ADR_I == dio_pkg::DIO_OFF_DOUT)
            rdat_nxt = {24'h0, dout_r};
         else if (ADR_I == dio_pkg::DIO_OFF_ISTAT)
            rdat_nxt = {28'h0, ist_r};
         else if (ADR_I == dio_pkg::DIO_OFF_IMASK)
            rdat_nxt = {28'h0, imask_r};
         else
         begin
            ack_nxt  = 1'b0;
            err_nxt  = 1'b1;
            rdat_nxt = 32'h0;
         end
      end
      // a new event beats a same-cycle clear
      ist_nxt = ist_nxt | evt;
   end

   // all state registers
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         ctrl_r  <= dio_pkg::DIO_CTRL_RST;
         asgn_r  <= {8{dio_pkg::DIO_ASGN_RST}};
         man_r   <= 8'h00;
         ist_r   <= 4'h0;
         imask_r <= 4'h0;
         dout_r  <= 8'h00;
         st_r    <= '0;
         ack_r   <= 1'b0;
         err_r   <= 1'b0;
         rdat_r  <= 32'h0;
      end
      else
      begin
         ctrl_r  <= ctrl_nxt;
         asgn_r  <= asgn_nxt;
         man_r   <= man_nxt;
         ist_r   <= ist_nxt;
         imask_r <= imask_nxt;
         dout_r  <= dout_nxt;
         st_r    <= st_nxt;
         ack_r   <= ack_nxt;
         err_r   <= err_nxt;
         rdat_r  <= rdat_nxt;
      end
   end

   assign DAT_O   = rdat_r;
   assign ACK_O   = ack_r;
   assign ERR_O   = err_r;
   assign DOUT_O  = dout_r;
   assign STATE_O = st_r;
   assign IRQ_O   = |(ist_r & imask_r);

   // assertions
   sequence s_run_cause;
      RUN_CONTACT_I && ctrl_r[dio_pkg::DIO_CTRL_COMM_RUN];
   endsequence

   a_run_stop_prio: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_run_cause |=> STATE_O.run)
      else $error("run not taken");
   a_stop_forces: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (!RUN_CONTACT_I || !ctrl_r[dio_pkg::DIO_CTRL_COMM_RUN]) |=> !STATE_O.run)
      else $error("stop not forced");
   a_am_link: assert property (@(posedge MCLK_I) disable iff (RST_I)
      ctrl_r[dio_pkg::DIO_CTRL_AM_LINK] |=> STATE_O.manual == $past(AUTO_MANUAL_SELECT_I))
      else $error("auto/manual not from contact");
   a_rl_link: assert property (@(posedge MCLK_I) disable iff (RST_I)
      ctrl_r[dio_pkg::DIO_CTRL_RL_LINK] |=> STATE_O.remote == $past(REMOTE_LOCAL_SELECT_I))
      else $error("remote/local not from contact");
   a_none_off: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[0] == dio_pkg::DIO_A_NONE |=> !DOUT_O[0])
      else $error("unassigned output on");
   a_evor_out: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[5] == dio_pkg::DIO_A_EVOR |=> DOUT_O[5] ==
      $past(SRC_I.chan_event[0][1] | SRC_I.chan_event[1][1] | SRC_I.chan_event[2][1]
            | SRC_I.chan_event[3][1]))
      else $error("event or wrong");
   a_break_out: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[6] == dio_pkg::DIO_A_BREAK |=> DOUT_O[6] == $past(SRC_I.heater_break_alarm[2]))
      else $error("heater break channel wrong");
   a_burn_or: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[2] == dio_pkg::DIO_A_COMBO |=> DOUT_O[2] == $past(|SRC_I.burnout))
      else $error("burnout or wrong");
   a_rise_all: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[4] == dio_pkg::DIO_A_COMBO |=>
      DOUT_O[4] == $past(&(SRC_I.rise_done | ~SRC_I.rise_sel)))
      else $error("rise completion wrong");
   a_ack_one: assert property (@(posedge MCLK_I) disable iff (RST_I)
      ACK_O |=> !ACK_O)
      else $error("ack held");

   // a taken request is answered in the next cycle, then the answer drops
   sequence s_bus_take;
      CYC_I && STB_I && !ACK_O && !ERR_O;
   endsequence

   sequence s_bus_answer;
      (ACK_O || ERR_O) ##1 (!ACK_O && !ERR_O);
   endsequence

   a_bus_answer: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_bus_take |=> s_bus_answer)
      else $error("bus request not answered in one cycle");
   // a refused address must never also look accepted
   a_ack_err_excl: assert property (@(posedge MCLK_I) disable iff (RST_I)
      !(ACK_O && ERR_O))
      else $error("ack and err together");
   // an output change always leaves its sticky event behind
   a_dout_event: assert property (@(posedge MCLK_I) disable iff (RST_I)
      DOUT_O != $past(DOUT_O) |-> ist_r[dio_pkg::DIO_ST_DO])
      else $error("output change without event");
   // manual source on the second output
   a_man_out: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[1] == dio_pkg::DIO_A_MANUAL |=> DOUT_O[1] == $past(man_r[1]))
      else $error("manual output wrong");
   // one channel's events over a group; value 3 is the first channel
   a_chan_events: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[3] == dio_pkg::DIO_A_CH1 |=> DOUT_O[3] == $past(SRC_I.chan_event[0][3]))
      else $error("channel event routing wrong");
   // one event over the channels; value 7 is the first event
   a_event_chans: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[7] == dio_pkg::DIO_A_EV1 |=> DOUT_O[7] == $past(SRC_I.chan_event[3][0]))
      else $error("event channel routing wrong");
   // per channel burnout status
   a_burn_chan: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[0] == dio_pkg::DIO_A_BURN |=> DOUT_O[0] == $past(SRC_I.burnout[0]))
      else $error("burnout channel wrong");
   // combined value on a fourth position falls back to the manual bit
   a_combo_man: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[7] == dio_pkg::DIO_A_COMBO |=> DOUT_O[7] == $past(man_r[7]))
      else $error("combined fourth output wrong");
   // heater break summary from the current transformer module alone
   a_brk_ct_or: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[1] == dio_pkg::DIO_A_COMBO
      && ctrl_r[dio_pkg::DIO_CTRL_BRK_LSB +: 2] == dio_pkg::DIO_BRK_CT
      |=> DOUT_O[1] == $past(|SRC_I.ct_break))
      else $error("heater break summary wrong");
   // heater break summary from both modules together
   a_brk_both_or: assert property (@(posedge MCLK_I) disable iff (RST_I)
      asgn_r[5] == dio_pkg::DIO_A_COMBO
      && ctrl_r[dio_pkg::DIO_CTRL_BRK_LSB +: 2] == dio_pkg::DIO_BRK_BOTH
      |=> DOUT_O[5] == $past((|SRC_I.ct_break) | (|SRC_I.heater_break_alarm)))
      else $error("combined heater break summary wrong");
endmodule
